// ---- common/motor_output_pkg.sv ----
// Constants, register map and helper functions for the motor output stage.
// Assumes a single 25 MHz clock and an Avalon-MM slave with byte addresses.
//
// Contract
// - Servo PWM offers inverter and sign-magnitude formats; only the selected one is output.
// - Inverter format: 25 kHz, 0.2% at full negative, 50% at zero, 99.8% full positive.
// - Sign-magnitude format: 50 kHz, 0% at zero magnitude, 99.6% at full magnitude.
// - Sign-magnitude format puts command polarity on the sign output, magnitude on PWM.
// - Stepper axes emit one step pulse per motor step on the shared PWM/step output.
// - Each step pulse is active for half of the step period.
// - Step pulse polarity is selectable, active low or active high.
// - Stepper axes drive the sign/direction output with the commanded travel direction.
// - Error output goes low while any axis position error exceeds its limit.
// - Amplifier enable goes low on abort, and on error when off-on-error is set.
// - Servo mode refreshes the motor command once per sample period.
// - Motor-off mode holds the motor command at the programmed offset level.
// - Set-bit and clear-bit change one output line, leaving others unchanged.
// - Output port write sets every general-purpose output bit at once.
package motor_output_pkg;

  // ==========================================================
  // Clock and PWM timing
  localparam int CLK_HZ = 25_000_000;
  localparam int INV_PWM_HZ = 25_000;
  localparam int SM_PWM_HZ = 50_000;
  localparam int INV_PERIOD_CYC = CLK_HZ / INV_PWM_HZ;
  localparam int SM_PERIOD_CYC = CLK_HZ / SM_PWM_HZ;
  // Duty endpoints in tenths of a percent
  localparam int INV_MIN_TENTHS = 2;
  localparam int INV_MAX_TENTHS = 998;
  localparam int SM_MAX_TENTHS = 996;
  localparam int INV_DUTY_MIN = (INV_PERIOD_CYC * INV_MIN_TENTHS) / 1000;
  localparam int INV_DUTY_MAX = (INV_PERIOD_CYC * INV_MAX_TENTHS) / 1000;
  localparam int INV_DUTY_HALF = INV_PERIOD_CYC / 2;
  localparam int SM_DUTY_MAX = (SM_PERIOD_CYC * SM_MAX_TENTHS) / 1000;
  // Command to duty scale: right shift of the signed command
  localparam int CMD_SHIFT = 6;

  // ==========================================================
  // Widths
  localparam int CNT_W = 10;
  localparam int CMD_W = 16;
  localparam int GPIO_W = 16;
  localparam int ADDR_W = 8;
  localparam int IRQ_W = 3;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OFFSET = 8'h04;
  localparam logic [7:0] OFS_ERR_LIMIT = 8'h08;
  localparam logic [7:0] OFS_SAMPLE = 8'h0C;
  localparam logic [7:0] OFS_STEP_HALF = 8'h10;
  localparam logic [7:0] OFS_STEP_CMD = 8'h14;
  localparam logic [7:0] OFS_GPIO = 8'h18;
  localparam logic [7:0] OFS_GPIO_SET = 8'h1C;
  localparam logic [7:0] OFS_GPIO_CLR = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;

  // Control register fields and the step command direction bit
  localparam int CTRL_STEPPER = 0;
  localparam int CTRL_SIGN_MAG = 1;
  localparam int CTRL_STEP_HIGH = 2;
  localparam int CTRL_MOTOR_OFF = 3;
  localparam int CTRL_OFF_ON_ERR = 4;
  localparam int CTRL_AMP_ON = 5;
  localparam int STEP_DIR_BIT = 31;

  // Interrupt status fields
  localparam int IRQ_ERR = 0;
  localparam int IRQ_STEP_DONE = 1;
  localparam int IRQ_ABORT = 2;

  // Reset values
  localparam logic [15:0] SAMPLE_RST = 16'h61A8;
  localparam logic [15:0] STEP_HALF_RST = 16'h0064;
  localparam logic [15:0] ERR_LIMIT_RST = 16'h3FFF;

  // ==========================================================
  // Magnitude of a signed 16-bit value; full negative gives 16'h8000
  function automatic logic [15:0] abs16(input logic [15:0] v);
    abs16 = v[15] ? 16'(-v) : v;
  endfunction

  // Byte-enable merge of a write into an existing word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

endpackage

// ---- rtl/pwm_counter.sv ----
// Free-running PWM carrier with a duty latched at the start of each period.
// Assumes period and duty are stable enough to be sampled once per period.
`timescale 1ns/1ns
module pwm_counter
  import motor_output_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Carrier settings
  input wire logic [CNT_W-1:0] period,
  input wire logic [CNT_W-1:0] duty,
  // Waveform
  output logic pwm
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] duty;
    logic pwm;
  } pwm_state_t;

  pwm_state_t st;
  pwm_state_t st_d;

  // ==========================================================
  // Next state: count, reload duty at wrap, compare
  always_comb begin
    st_d = st;
    if (st.cnt >= period - CNT_W'(1)) begin
      st_d.cnt = '0;
      st_d.duty = duty;
    end else begin
      st_d.cnt = st.cnt + CNT_W'(1);
    end
    st_d.pwm = st_d.cnt < st_d.duty;
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else if (ce) begin
      st <= st_d;
    end
  end

  assign pwm = st.pwm;

  a_zero_duty: assert property (@(posedge clk) disable iff (!rstn) st.duty == '0 |-> !pwm)
    else $error("pwm high with zero duty");

endmodule

// ---- rtl/motor_output_pwm_step.sv ----
// Single-axis output stage: servo PWM, step/direction, enables, error and outputs.
// Assumes a 25 MHz clock, synchronous inputs and an Avalon-MM master with waitrequest.
`timescale 1ns/1ns
module motor_output_pwm_step
  import motor_output_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Servo loop side
  input wire logic [CMD_W-1:0] servo_cmd,
  input wire logic [CMD_W-1:0] pos_error,
  input wire logic other_axis_error,
  input wire logic abort_n,
  // Pins toward bridge or driver
  output logic pwm_step_out,
  output logic sign_dir_out,
  output logic amp_enable,
  output logic error_n,
  output logic [GPIO_W-1:0] gpio_out,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    logic stepper;
    logic sign_mag;
    logic step_high;
    logic motor_off;
    logic off_on_err;
    logic amp_on;
    logic [15:0] offset;
    logic [15:0] err_limit;
    logic [15:0] sample_per;
    logic [15:0] step_half;
    logic [15:0] sample_cnt;
    logic [15:0] cmd_act;
    logic [15:0] step_left;
    logic [15:0] step_cnt;
    logic step_dir;
    logic step_phase;
    logic [GPIO_W-1:0] gpio;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic err_prev;
    logic error_n;
    logic pwm_step;
    logic sign_dir;
    logic irq;
  } out_state_t;

  out_state_t st;
  out_state_t st_d;

  // ==========================================================
  // Combinational helpers
  logic req;
  logic take;
  logic wr;
  logic sample_tick;
  logic err_now;
  logic pwm_raw;
  logic [31:0] rd;
  logic [31:0] merged;
  logic [CNT_W-1:0] period_sel;
  logic [CNT_W-1:0] duty_sel;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic step_done;
  int inv_raw;
  logic [15:0] mag;

  // Bus handshake: first cycle raises the answer, second cycle commits
  assign req = read | write;
  assign take = req & ~st.wait_req;
  assign wr = write & take;

  // Sample tick and error detection
  assign sample_tick = (st.sample_cnt + 16'h0001) >= st.sample_per;
  assign err_now = (abs16(pos_error) > st.err_limit) | other_axis_error;

  // ==========================================================
  // Duty from the active command, linear and saturating
  always_comb begin
    inv_raw = INV_DUTY_HALF + (int'(signed'(st.cmd_act)) >>> CMD_SHIFT);
    if (inv_raw < INV_DUTY_MIN) begin
      inv_raw = INV_DUTY_MIN;
    end else if (inv_raw > INV_DUTY_MAX) begin
      inv_raw = INV_DUTY_MAX;
    end
    mag = abs16(st.cmd_act) >> CMD_SHIFT;
    if (mag > 16'(SM_DUTY_MAX)) begin
      mag = 16'(SM_DUTY_MAX);
    end
    if (st.sign_mag) begin
      period_sel = CNT_W'(SM_PERIOD_CYC);
      duty_sel = mag[CNT_W-1:0];
    end else begin
      period_sel = CNT_W'(INV_PERIOD_CYC);
      duty_sel = inv_raw[CNT_W-1:0];
    end
  end

  pwm_counter u_pwm (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .period(period_sel),
    .duty(duty_sel),
    .pwm(pwm_raw)
  );

  // ==========================================================
  // Register read mux
  always_comb begin
    rd = 32'h0000_0000;
    unique case (address)
      OFS_CTRL: begin
        rd[CTRL_STEPPER] = st.stepper;
        rd[CTRL_SIGN_MAG] = st.sign_mag;
        rd[CTRL_STEP_HIGH] = st.step_high;
        rd[CTRL_MOTOR_OFF] = st.motor_off;
        rd[CTRL_OFF_ON_ERR] = st.off_on_err;
        rd[CTRL_AMP_ON] = st.amp_on;
      end
      OFS_OFFSET: rd[15:0] = st.offset;
      OFS_ERR_LIMIT: rd[15:0] = st.err_limit;
      OFS_SAMPLE: rd[15:0] = st.sample_per;
      OFS_STEP_HALF: rd[15:0] = st.step_half;
      OFS_STEP_CMD: rd = {st.step_dir, 15'h0000, st.step_left};
      OFS_GPIO: rd[GPIO_W-1:0] = st.gpio;
      OFS_STATUS: rd = {st.cmd_act, 12'h000, st.sign_dir, (st.step_left != 16'h0000),
                        ~st.error_n, st.amp_on};
      OFS_IRQ_STAT: rd[IRQ_W-1:0] = st.irq_stat;
      OFS_IRQ_MASK: rd[IRQ_W-1:0] = st.irq_mask;
      default: rd = 32'h0000_0000;
    endcase
  end

  // Word image for byte-enable writes
  always_comb begin
    unique case (address)
      OFS_CTRL: merged = {26'h0, st.amp_on, st.off_on_err, st.motor_off, st.step_high,
                          st.sign_mag, st.stepper};
      OFS_OFFSET: merged = {16'h0000, st.offset};
      OFS_ERR_LIMIT: merged = {16'h0000, st.err_limit};
      OFS_SAMPLE: merged = {16'h0000, st.sample_per};
      OFS_STEP_HALF: merged = {16'h0000, st.step_half};
      OFS_STEP_CMD: merged = {st.step_dir, 15'h0000, st.step_left};
      OFS_GPIO: merged = {16'h0000, st.gpio};
      OFS_IRQ_MASK: merged = {29'h0, st.irq_mask};
      default: merged = 32'h0000_0000;
    endcase
    merged = be_merge(merged, writedata, byteenable);
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st;
    irq_clr = '0;
    step_done = 1'b0;

    // Answer one cycle after the request is seen
    st_d.wait_req = ~(req & st.wait_req);
    if (read & st.wait_req) begin
      st_d.rdata = rd;
    end

    // Register writes commit on the waitrequest-low edge
    if (wr) begin
      unique case (address)
        OFS_CTRL: begin
          st_d.stepper = merged[CTRL_STEPPER];
          st_d.sign_mag = merged[CTRL_SIGN_MAG];
          st_d.step_high = merged[CTRL_STEP_HIGH];
          st_d.motor_off = merged[CTRL_MOTOR_OFF];
          st_d.off_on_err = merged[CTRL_OFF_ON_ERR];
          st_d.amp_on = merged[CTRL_AMP_ON];
        end
        OFS_OFFSET: st_d.offset = merged[15:0];
        OFS_ERR_LIMIT: st_d.err_limit = merged[15:0];
        OFS_SAMPLE: st_d.sample_per = merged[15:0];
        OFS_STEP_HALF: st_d.step_half = merged[15:0];
        OFS_STEP_CMD: begin
          st_d.step_left = merged[15:0];
          st_d.step_dir = merged[STEP_DIR_BIT];
          st_d.step_cnt = 16'h0000;
          st_d.step_phase = 1'b0;
        end
        OFS_GPIO: st_d.gpio = merged[GPIO_W-1:0];
        OFS_GPIO_SET: begin
          if (byteenable[0]) begin
            st_d.gpio[writedata[3:0]] = 1'b1;
          end
        end
        OFS_GPIO_CLR: begin
          if (byteenable[0]) begin
            st_d.gpio[writedata[3:0]] = 1'b0;
          end
        end
        OFS_IRQ_STAT: irq_clr = merged[IRQ_W-1:0];
        OFS_IRQ_MASK: st_d.irq_mask = merged[IRQ_W-1:0];
        default: st_d.gpio = st.gpio;
      endcase
    end

    // Sample period counter and command refresh
    if (sample_tick) begin
      st_d.sample_cnt = 16'h0000;
      st_d.cmd_act = st.motor_off ? st.offset : servo_cmd;
    end else begin
      st_d.sample_cnt = st.sample_cnt + 16'h0001;
    end

    // Step train: two half periods per step, counted down at the end
    if (st.step_left != 16'h0000 && !(wr && address == OFS_STEP_CMD)) begin
      if ((st.step_cnt + 16'h0001) >= st.step_half) begin
        st_d.step_cnt = 16'h0000;
        st_d.step_phase = ~st.step_phase;
        if (st.step_phase) begin
          st_d.step_left = st.step_left - 16'h0001;
          step_done = st.step_left == 16'h0001;
        end
      end else begin
        st_d.step_cnt = st.step_cnt + 16'h0001;
      end
    end

    // Amplifier enable: hardware shutdown beats a software set
    if (!abort_n || (st_d.off_on_err && err_now)) begin
      st_d.amp_on = 1'b0;
    end

    // Error pin and event capture
    st_d.error_n = ~err_now;
    st_d.err_prev = err_now;
    irq_set = '0;
    irq_set[IRQ_ERR] = err_now & ~st.err_prev;
    irq_set[IRQ_STEP_DONE] = step_done;
    irq_set[IRQ_ABORT] = ~abort_n;
    st_d.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);

    // Output pin selection
    if (st_d.stepper) begin
      st_d.pwm_step = st_d.step_phase ? st_d.step_high : ~st_d.step_high;
      st_d.sign_dir = st_d.step_dir;
    end else begin
      st_d.pwm_step = pwm_raw;
      st_d.sign_dir = st_d.cmd_act[CMD_W-1];
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.wait_req <= 1'b1;
      st.sample_per <= SAMPLE_RST;
      st.step_half <= STEP_HALF_RST;
      st.err_limit <= ERR_LIMIT_RST;
      st.error_n <= 1'b1;
      st.step_phase <= 1'b0;
    end else if (ce) begin
      st <= st_d;
    end
  end

  // Outputs straight from the state register
  assign readdata = st.rdata;
  assign waitrequest = st.wait_req;
  assign pwm_step_out = st.pwm_step;
  assign sign_dir_out = st.sign_dir;
  assign amp_enable = st.amp_on;
  assign error_n = st.error_n;
  assign gpio_out = st.gpio;
  assign irq = st.irq;

  // ==========================================================
  // Checks
  a_error_low: assert property (@(posedge clk) disable iff (!rstn)
    ce && err_now |=> !error_n)
    else $error("error pin not low on excess error");

  a_amp_abort: assert property (@(posedge clk) disable iff (!rstn)
    ce && !abort_n |=> !amp_enable ##1 (!amp_enable || $past(wr)))
    else $error("amp enable not dropped on abort");

  a_amp_off_err: assert property (@(posedge clk) disable iff (!rstn)
    ce && st.off_on_err && err_now && !wr |=> !amp_enable)
    else $error("amp enable not dropped on error");

  a_offset_hold: assert property (@(posedge clk) disable iff (!rstn)
    ce && sample_tick && st.motor_off |=> st.cmd_act == $past(st.offset))
    else $error("motor off did not load offset");

  a_cmd_refresh: assert property (@(posedge clk) disable iff (!rstn)
    ce && !sample_tick |=> $stable(st.cmd_act))
    else $error("command changed between samples");

  a_inv_range: assert property (@(posedge clk) disable iff (!rstn)
    !st.sign_mag |-> duty_sel >= CNT_W'(INV_DUTY_MIN) && duty_sel <= CNT_W'(INV_DUTY_MAX))
    else $error("inverter duty outside limits");

  a_sm_range: assert property (@(posedge clk) disable iff (!rstn)
    st.sign_mag |-> duty_sel <= CNT_W'(SM_DUTY_MAX) && period_sel == CNT_W'(SM_PERIOD_CYC))
    else $error("sign-magnitude duty outside limits");

  a_gpio_set: assert property (@(posedge clk) disable iff (!rstn)
    ce && wr && address == OFS_GPIO_SET && byteenable[0] |=>
      gpio_out[$past(writedata[3:0])] && ((gpio_out ^ $past(gpio_out)) & ~(16'h0001 <<
      $past(writedata[3:0]))) == 16'h0000)
    else $error("set bit disturbed other lines");

  a_gpio_port: assert property (@(posedge clk) disable iff (!rstn)
    ce && wr && address == OFS_GPIO && byteenable[1:0] == 2'b11 |=>
      gpio_out == $past(writedata[GPIO_W-1:0]))
    else $error("port write not applied");

  a_step_idle: assert property (@(posedge clk) disable iff (!rstn)
    st.stepper && !st.step_phase |-> pwm_step_out == ~st.step_high)
    else $error("step pin not at inactive level");

  a_step_dir: assert property (@(posedge clk) disable iff (!rstn)
    ce && st_d.stepper |=> sign_dir_out == st.step_dir)
    else $error("direction pin does not follow command");

endmodule

// ---- dv/step_driver_model.sv ----
// Model of an external step driver: counts step pulses, measures the active width
// and latches the direction seen at each pulse. Assumes the output stage's clock.
`timescale 1ns/1ns
module step_driver_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pins from the output stage
  input wire logic step,
  input wire logic dir,
  // Settings from the bench
  input wire logic active_high,
  input wire logic clr,
  // Observations
  output int pulses,
  output int width,
  output logic dir_seen
);
  int run;

  // ==========================================================
  // Pulse counting at the selected active level
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulses <= 0;
      width <= 0;
      run <= 0;
      dir_seen <= 1'b0;
    end else if (clr) begin
      pulses <= 0;
      width <= 0;
      run <= 0;
    end else if (step === active_high) begin
      run <= run + 1;
      if (run == 0) begin
        pulses <= pulses + 1;
        dir_seen <= dir;
      end
    end else if (run != 0) begin
      width <= run;
      run <= 0;
    end
  end
endmodule

// ---- dv/motor_output_pwm_step_tb.sv ----
// Self-checking bench for the motor output stage: bus tasks, PWM, step and error tests.
// Assumes a 25 MHz clock and the step driver model on the step/direction pins.
`timescale 1ns/1ns
module motor_output_pwm_step_tb;
  import motor_output_pkg::*;
  logic clk, rstn, read, write, waitrequest, irq;
  logic [ADDR_W-1:0] address;
  logic [31:0] writedata, readdata, rv;
  logic [CMD_W-1:0] servo_cmd, pos_error;
  logic other_axis_error, abort_n, pwm_step_out, sign_dir_out, amp_enable, error_n;
  logic [GPIO_W-1:0] gpio_out;
  logic step_high, clr;
  int pulses, width, fail_count, num_checks, cyc, hi;
  logic dir_seen;
  logic [15:0] cmds [6] = '{16'h0000, 16'h1900, 16'h7FFF, 16'h8000, 16'hF380, 16'h8000};
  int exps [6] = '{500, 600, 998, 2, 50, 498};

  // ==========================================================
  // Clock and instances
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  motor_output_pwm_step i_motor_output_pwm_step (.clk(clk), .rstn(rstn), .ce(1'b1),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .servo_cmd(servo_cmd), .pos_error(pos_error), .other_axis_error(other_axis_error),
    .abort_n(abort_n), .pwm_step_out(pwm_step_out), .sign_dir_out(sign_dir_out),
    .amp_enable(amp_enable), .error_n(error_n), .gpio_out(gpio_out), .irq(irq));
  step_driver_model i_step_driver_model (.clk(clk), .rstn(rstn), .step(pwm_step_out),
    .dir(sign_dir_out), .active_high(step_high), .clr(clr), .pulses(pulses),
    .width(width), .dir_seen(dir_seen));

  // ==========================================================
  // Checking, verdict and timeout
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      final_report();
    end
  end

  // ==========================================================
  // Avalon-MM master tasks and helpers
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rv = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    @(posedge clk); // Committed value is on the pins from here
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(n, rv, e);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic measure(input int n);
    hi = 0;
    repeat (n) begin
      @(posedge clk);
      if (pwm_step_out === 1'b1) hi++;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {rstn, read, write, other_axis_error, step_high} = '0;
    // Step model held clear: servo phases leave the pin unloaded
    clr = 1'b1;
    {address, writedata, servo_cmd, pos_error} = '0;
    abort_n = 1'b1;
    fail_count = 0;
    num_checks = 0;
    cyc = 0;
    wait_cyc(5);
    rstn <= 1'b1;
    check("amp_enable", amp_enable, 0);
    check("error_n", error_n, 1);
    rdc("sample", OFS_SAMPLE, 32'h0000_61A8);
    rdc("step_half", OFS_STEP_HALF, 32'h0000_0064);
    rdc("err_limit", OFS_ERR_LIMIT, 32'h0000_3FFF);
    rdc("unmapped", 8'h40, 32'h0);
    // Output port write, then single bit set and clear
    wr(OFS_GPIO, 32'h0000_00F0);
    check("gpio", gpio_out, 16'h00F0);
    wr(OFS_GPIO_SET, 32'h3);
    wr(OFS_GPIO_CLR, 32'h4);
    check("gpio", gpio_out, 16'h00E8);
    // Servo PWM in inverter then sign-magnitude format
    wr(OFS_SAMPLE, 32'hA);
    for (int i = 0; i < 6; i++) begin
      if (i == 4) wr(OFS_CTRL, 32'h22);
      if (i == 0) wr(OFS_CTRL, 32'h20);
      servo_cmd <= cmds[i];
      wait_cyc(1100);
      measure(i < 4 ? INV_PERIOD_CYC : SM_PERIOD_CYC);
      check("duty", hi, exps[i]);
      if (i > 3) check("sign", sign_dir_out, 1);
    end
    servo_cmd <= 16'h1900;
    wait_cyc(1100);
    check("sign", sign_dir_out, 0);
    // Motor-off holds the offset level
    wr(OFS_OFFSET, 32'h0C80);
    wr(OFS_CTRL, 32'h28);
    wait_cyc(1100);
    measure(INV_PERIOD_CYC);
    check("offset duty", hi, 550);
    rdc("status", OFS_STATUS, 32'h0C80_0001);
    // Error output, off-on-error, interrupt and abort
    wr(OFS_IRQ_MASK, 32'h5);
    wr(OFS_CTRL, 32'h30);
    wr(OFS_ERR_LIMIT, 32'h0000_0064);
    pos_error <= 16'h00C8;
    wait_cyc(3);
    check("error_n", error_n, 0);
    check("amp_enable", amp_enable, 0);
    check("irq", irq, 1);
    rdc("irq_stat", OFS_IRQ_STAT, 32'h1);
    pos_error <= 16'hFF9C;
    wait_cyc(3);
    check("error_n", error_n, 1);
    other_axis_error <= 1'b1;
    wait_cyc(3);
    check("error_n", error_n, 0);
    other_axis_error <= 1'b0;
    wait_cyc(3);
    wr(OFS_IRQ_STAT, 32'h1);
    check("irq", irq, 0);
    wr(OFS_CTRL, 32'h20);
    check("amp_enable", amp_enable, 1);
    abort_n <= 1'b0;
    wait_cyc(3);
    check("amp_enable", amp_enable, 0);
    check("irq", irq, 1);
    abort_n <= 1'b1;
    wr(OFS_IRQ_STAT, 32'h7);
    check("irq", irq, 0);
    // Step trains, both polarities and directions
    wr(OFS_STEP_HALF, 32'h4);
    for (int p = 0; p < 2; p++) begin
      step_high <= !p[0];
      wr(OFS_CTRL, p == 0 ? 32'h25 : 32'h21);
      wait_cyc(3);
      clr <= 1'b1;
      wait_cyc(1);
      clr <= 1'b0;
      wr(OFS_STEP_CMD, p == 0 ? 32'h8000_0003 : 32'h0000_0002);
      wait_cyc(40);
      check("pulses", pulses, 3 - p);
      check("width", width, 4);
      check("dir", dir_seen, !p[0]);
      rdc("irq_stat", OFS_IRQ_STAT, 32'h2);
      wr(OFS_IRQ_STAT, 32'h2);
    end
    final_report();
  end
endmodule
